// ---- rtl/trx_pkg.sv ----
// Constants, register map and types of the receive pattern monitor block
package trx_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
  localparam int SECOND_MS = 1000;
  localparam int RESYNC_STEP_MS = 8;
  localparam int SYNC_MATCH = 32;
  localparam int LOSS_ERR = 4;
  localparam int NUM_SLOTS = 24;

  // Word indexes; byte address is four times the index
  localparam logic [5:0] IDX_PMC = 6'h04;
  localparam logic [5:0] IDX_PAT_LO = 6'h05;
  localparam logic [5:0] IDX_PAT_HI = 6'h06;
  localparam logic [5:0] IDX_SLOT_LO = 6'h07;
  localparam logic [5:0] IDX_SLOT_HI = 6'h08;
  localparam logic [5:0] IDX_MASK = 6'h09;
  localparam logic [5:0] IDX_MODE = 6'h0a;
  localparam logic [5:0] IDX_CMD = 6'h10;
  localparam logic [5:0] IDX_CNT_PAT = 6'h11;
  localparam logic [5:0] IDX_CNT_CRC = 6'h12;

  localparam logic [15:0] RST_PMC = 16'h001f;
  localparam logic [15:0] RST_PAT_LO = 16'h0000;
  localparam logic [15:0] RST_PAT_HI = 16'h0000;
  localparam logic [15:0] RST_SLOT_LO = 16'hffff;
  localparam logic [15:0] RST_SLOT_HI = 16'h00ff;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;

  localparam int PMC_EN_BIT = 7;
  localparam int PMC_SEL_LSB = 5;
  localparam int PMC_LEN_LSB = 0;
  localparam int MODE_BUF_BIT = 0;
  localparam int MODE_AUTO_BIT = 1;
  localparam int MODE_DLY_LSB = 2;
  localparam int CMD_FORCE_BIT = 0;
  localparam int CMD_SYNC_BIT = 1;
  localparam int CMD_PEND_BIT = 2;

  localparam int VEC_TMR400 = 11;
  localparam int VEC_CRC = 10;
  localparam int VEC_DENS = 9;
  localparam int VEC_ERRSEC = 3;
  localparam int VEC_SECOND = 2;
  localparam int VEC_LOOP = 1;
  localparam int VEC_PATTERN = 0;

  typedef enum logic [1:0] {
    PSEL_P15 = 2'b00,
    PSEL_P20 = 2'b01,
    PSEL_FIX = 2'b11
  } trx_psel_t;

  typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_SYNC} trx_chk_state_t;
endpackage

// ---- rtl/trx_err_cnt.sv ----
// Error counter with direct or once-per-second buffered readout
`timescale 1ns/1ps
module trx_err_cnt
  import trx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic evt,
  input wire logic buffered,
  input wire logic second_tick,
  input wire logic rd_clr,
  output logic [15:0] count
);
  logic [15:0] cnt_q;
  logic [15:0] hid_q;

  assign count = cnt_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else if (!buffered)
    begin
      // An error in the clearing cycle survives the clear
      if (rd_clr)
        cnt_q <= {15'h0000, evt};
      else if (evt && !(&cnt_q))
        cnt_q <= cnt_q + 16'h0001;
    end
    else if (second_tick)
      cnt_q <= hid_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hid_q <= 16'h0000;
    else if (!buffered)
      hid_q <= 16'h0000;
    else if (second_tick)
      hid_q <= {15'h0000, evt};
    else if (evt && !(&hid_q))
      hid_q <= hid_q + 16'h0001;
  end

  property p_rd_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    !buffered && rd_clr && !evt |=> cnt_q == 16'h0000;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("count not cleared");

  property p_copy;
    @(posedge ref_clk) disable iff (!rst_n)
    buffered && second_tick |=> cnt_q == $past(hid_q) && hid_q <= 16'h0001;
  endproperty
  a_copy: assert property (p_copy) else $error("buffered copy wrong");
endmodule

// ---- rtl/trx_prbs_chk.sv ----
// Pattern synchronizer and comparator for PRBS and fixed patterns
`timescale 1ns/1ps
module trx_prbs_chk
  import trx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] sel,
  input wire logic [4:0] len,
  input wire logic [31:0] pattern,
  input wire logic bit_vld,
  input wire logic bit_in,
  output logic sync,
  output logic err
);
  trx_chk_state_t st_q;
  trx_chk_state_t st_d;
  logic [19:0] hist_q;
  logic [4:0] idx_q;
  logic [4:0] run_q;
  logic [1:0] bad_q;
  logic sync_q;
  logic err_q;
  logic active;
  logic expect_bit;
  logic hit;

  // Reserved select code leaves the monitor idle
  assign active = enable && (sel == PSEL_P15 || sel == PSEL_P20 ||
    sel == PSEL_FIX);
  assign hit = bit_in == expect_bit;
  assign sync = sync_q;
  assign err = err_q;

  always_comb
  begin
    unique case (sel)
      PSEL_P15: expect_bit = hist_q[14] ^ hist_q[13];
      PSEL_P20: expect_bit = hist_q[19] ^ hist_q[16];
      default: expect_bit = pattern[idx_q];
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    if (!active)
      st_d = ST_OFF;
    else
      unique case (st_q)
        ST_OFF: st_d = ST_HUNT;
        ST_HUNT:
          if (bit_vld && hit && run_q == 5'(SYNC_MATCH - 1))
            st_d = ST_SYNC;
        ST_SYNC:
          if (bit_vld && !hit && bad_q == 2'(LOSS_ERR - 1))
            st_d = ST_HUNT;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= ST_OFF;
    else
      st_q <= st_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_q <= 1'b0;
    else
      sync_q <= st_d == ST_SYNC;
  end

  // Self-synchronising: history holds received bits, not a local LFSR
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hist_q <= 20'h00000;
    else if (bit_vld)
      hist_q <= {hist_q[18:0], bit_in};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      idx_q <= 5'h00;
    else if (st_q == ST_OFF)
      idx_q <= len;
    else if (bit_vld)
    begin
      if (st_q == ST_HUNT && !hit)
        idx_q <= len;
      else if (idx_q == 5'h00)
        idx_q <= len;
      else
        idx_q <= idx_q - 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= 5'h00;
    else if (st_q != ST_HUNT)
      run_q <= 5'h00;
    else if (bit_vld)
      run_q <= hit ? run_q + 5'h01 : 5'h00;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_q <= 2'h0;
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= st_q == ST_SYNC && bit_vld && !hit;
      if (st_q != ST_SYNC || (bit_vld && hit))
        bad_q <= 2'h0;
      else if (bit_vld)
        bad_q <= bad_q + 2'h1;
    end
  end

  property p_off;
    @(posedge ref_clk) disable iff (!rst_n)
    !enable |=> !sync_q ##1 !sync_q;
  endproperty
  a_off: assert property (p_off) else $error("sync while disabled");

  property p_lock;
    @(posedge ref_clk) disable iff (!rst_n)
    active && st_q == ST_HUNT && bit_vld && hit &&
      run_q == 5'(SYNC_MATCH - 1) |=> sync_q;
  endproperty
  a_lock: assert property (p_lock) else $error("no lock");

  property p_err;
    @(posedge ref_clk) disable iff (!rst_n)
    err_q |-> $past(st_q) == ST_SYNC && $past(bit_vld);
  endproperty
  a_err: assert property (p_err) else $error("error outside sync");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    st_q == ST_SYNC && st_d == ST_SYNC && bit_vld && idx_q == 5'h00
      |=> idx_q == $past(len);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pattern wrap wrong");
endmodule

// ---- rtl/trx_top.sv ----
// Receive pattern monitor, interrupt mask and resync control, one channel
// What this block does
// - With the enable bit set the synchronizer locks to the chosen pattern; cleared, it idles.
// - Select 00 picks 2^15-1, 01 picks 2^20-1, 11 the fixed pattern, 10 is reserved.
// - The fixed pattern is length field plus one bits long, top used bit first.
// - In sync the fixed pattern is compared top bit down to bit 0, repeating until disabled or until 4 errors in a row drop sync.
// - The 32-bit fixed pattern sits in a low-word and a high-word register.
// - Only slots whose select bit is set are monitored, joined into one stream.
// - A set mask bit suppresses its interrupt vector; a clear one lets it through.
// - Mask bits 11 down to 0 cover 400 ms timer through pattern-monitor status.
// - A generated vector does not itself drive the interrupt pin.
// - The resync delay is (field plus one) times 8 ms.
// - With auto check on, resync starts by itself after the delay unless software began one.
// - Unbuffered counters count live and clear when a read of them ends.
// - Buffered counters count hidden and are copied and reset once per second.
// - A change of any receive status level can raise a vector, subject to the mask.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module trx_top
  import trx_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic [4:0] rx_slot,
  input wire logic [6:0] rx_alarm_lvl,
  input wire logic rx_crc_evt,
  input wire logic rx_tmr400_evt,
  input wire logic rx_lof,
  output logic [11:0] irq_vector,
  output logic resync_start,
  output logic pattern_sync,
  output logic pattern_error
);
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic [7:0] pmc_q;
  logic [15:0] pat_lo_q;
  logic [15:0] pat_hi_q;
  logic [15:0] slot_lo_q;
  logic [7:0] slot_hi_q;
  logic [11:0] mask_q;
  logic [4:0] mode_q;
  logic force_q;
  logic [5:0] idx;
  logic wr;
  logic rd;
  logic [23:0] slot_mask;
  logic slot_sel;
  logic vld_q;
  logic bit_q;
  logic sync;
  logic err;
  logic [15:0] cnt_pat;
  logic [15:0] cnt_crc;
  logic [MS_W-1:0] ms_cnt_q;
  logic ms_tick;
  logic [9:0] sec_cnt_q;
  logic second_q;
  logic errsec_q;
  logic errsec_evt_q;
  logic lof_q;
  logic pend_q;
  logic [6:0] dly_q;
  logic [6:0] dly_end;
  logic resync_q;
  logic [7:0] lvl_q;
  logic [7:0] chg;
  logic [11:0] src;
  logic [11:0] vec_q;

  assign idx = avs_address[7:2];
  assign wr = avs_write && !wait_q;
  assign rd = avs_read && !wait_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq_vector = vec_q;
  assign resync_start = resync_q;
  assign pattern_sync = sync;
  assign pattern_error = err;

  // One wait cycle per access; idle waitrequest stays high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read || avs_write) && wait_q);
  end

  always_comb
  begin
    rd_d = 32'h00000000;
    unique case (idx)
      IDX_PMC: rd_d[7:0] = pmc_q;
      IDX_PAT_LO: rd_d[15:0] = pat_lo_q;
      IDX_PAT_HI: rd_d[15:0] = pat_hi_q;
      IDX_SLOT_LO: rd_d[15:0] = slot_lo_q;
      IDX_SLOT_HI: rd_d[7:0] = slot_hi_q;
      IDX_MASK: rd_d[11:0] = mask_q;
      IDX_MODE: rd_d[4:0] = mode_q;
      IDX_CMD:
      begin
        rd_d[CMD_SYNC_BIT] = sync;
        rd_d[CMD_PEND_BIT] = pend_q;
      end
      IDX_CNT_PAT: rd_d[15:0] = cnt_pat;
      IDX_CNT_CRC: rd_d[15:0] = cnt_crc;
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else if (avs_read && wait_q)
      rdata_q <= rd_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pmc_q <= RST_PMC[7:0];
      pat_lo_q <= RST_PAT_LO;
      pat_hi_q <= RST_PAT_HI;
    end
    else if (wr && idx == IDX_PMC)
      pmc_q <= avs_writedata[7:0];
    else if (wr && idx == IDX_PAT_LO)
      pat_lo_q <= avs_writedata[15:0];
    else if (wr && idx == IDX_PAT_HI)
      pat_hi_q <= avs_writedata[15:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_lo_q <= RST_SLOT_LO;
      slot_hi_q <= RST_SLOT_HI[7:0];
    end
    else if (wr && idx == IDX_SLOT_LO)
      slot_lo_q <= avs_writedata[15:0];
    else if (wr && idx == IDX_SLOT_HI)
      slot_hi_q <= avs_writedata[7:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= RST_MASK[11:0];
      mode_q <= RST_MODE[4:0];
    end
    else if (wr && idx == IDX_MASK)
      mask_q <= avs_writedata[11:0];
    else if (wr && idx == IDX_MODE)
      mode_q <= avs_writedata[4:0];
  end

  // Force command is self-clearing
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      force_q <= 1'b0;
    else
      force_q <= wr && idx == IDX_CMD && avs_writedata[CMD_FORCE_BIT];
  end

  // Slots beyond the mask width are never monitored
  assign slot_mask = {slot_hi_q, slot_lo_q};
  assign slot_sel = rx_slot < 5'(NUM_SLOTS) && slot_mask[rx_slot];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vld_q <= 1'b0;
      bit_q <= 1'b0;
    end
    else
    begin
      vld_q <= rx_bit_en && slot_sel;
      bit_q <= rx_bit;
    end
  end

  trx_prbs_chk u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(pmc_q[PMC_EN_BIT]),
    .sel(pmc_q[PMC_SEL_LSB +: 2]),
    .len(pmc_q[PMC_LEN_LSB +: 5]),
    .pattern({pat_hi_q, pat_lo_q}),
    .bit_vld(vld_q),
    .bit_in(bit_q),
    .sync(sync),
    .err(err)
  );

  trx_err_cnt u_cnt_pat (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(err),
    .buffered(mode_q[MODE_BUF_BIT]),
    .second_tick(second_q),
    .rd_clr(rd && idx == IDX_CNT_PAT),
    .count(cnt_pat)
  );

  trx_err_cnt u_cnt_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(rx_crc_evt),
    .buffered(mode_q[MODE_BUF_BIT]),
    .second_tick(second_q),
    .rd_clr(rd && idx == IDX_CNT_CRC),
    .count(cnt_crc)
  );

  assign ms_tick = ms_cnt_q == MS_W'(MS_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ms_cnt_q <= '0;
    else
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + MS_W'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_cnt_q <= 10'h000;
      second_q <= 1'b0;
    end
    else
    begin
      second_q <= ms_tick && sec_cnt_q == 10'(SECOND_MS - 1);
      if (ms_tick)
        sec_cnt_q <= sec_cnt_q == 10'(SECOND_MS - 1) ? 10'h000 :
          sec_cnt_q + 10'h001;
    end
  end

  // A CRC error in the tick cycle still marks the ending second
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      errsec_q <= 1'b0;
      errsec_evt_q <= 1'b0;
    end
    else
    begin
      errsec_evt_q <= second_q && (errsec_q || rx_crc_evt);
      errsec_q <= second_q ? 1'b0 : errsec_q || rx_crc_evt;
    end
  end

  assign dly_end = 7'(({4'h0, mode_q[MODE_DLY_LSB +: 3]} + 7'h01) *
    7'(RESYNC_STEP_MS) - 7'h01);

  // Pending ends on software force, on expiry, or when frame returns
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lof_q <= 1'b0;
      pend_q <= 1'b0;
      dly_q <= 7'h00;
      resync_q <= 1'b0;
    end
    else
    begin
      lof_q <= rx_lof;
      resync_q <= force_q || (pend_q && ms_tick && dly_q == dly_end);
      if (force_q || !rx_lof || (ms_tick && dly_q == dly_end))
        pend_q <= 1'b0;
      else if (rx_lof && !lof_q && mode_q[MODE_AUTO_BIT])
        pend_q <= 1'b1;
      if (!pend_q)
        dly_q <= 7'h00;
      else if (ms_tick)
        dly_q <= dly_q + 7'h01;
    end
  end

  assign chg = {rx_alarm_lvl, sync} ^ lvl_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lvl_q <= 8'h00;
    else
      lvl_q <= {rx_alarm_lvl, sync};
  end

  always_comb
  begin
    src = 12'h000;
    src[VEC_TMR400] = rx_tmr400_evt;
    src[VEC_CRC] = rx_crc_evt;
    src[VEC_DENS -: 6] = chg[7:2];
    src[VEC_ERRSEC] = errsec_evt_q;
    src[VEC_SECOND] = second_q;
    src[VEC_LOOP] = chg[1];
    src[VEC_PATTERN] = chg[0];
  end

  // Vectors only; pin assertion belongs to the interrupt controller
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      vec_q <= 12'h000;
    else
      vec_q <= src & ~mask_q;
  end

  property p_mask;
    @(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> (vec_q & $past(mask_q)) == 12'h000;
  endproperty
  a_mask: assert property (p_mask) else $error("masked vector seen");

  property p_second_vec;
    @(posedge ref_clk) disable iff (!rst_n)
    second_q && !mask_q[VEC_SECOND] |=> vec_q[VEC_SECOND];
  endproperty
  a_second_vec: assert property (p_second_vec) else $error("no tick vector");

  property p_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    rx_bit_en && rx_slot >= 5'(NUM_SLOTS) |=> !vld_q;
  endproperty
  a_gate: assert property (p_gate) else $error("bad slot passed");

  property p_resync;
    @(posedge ref_clk) disable iff (!rst_n)
    resync_q |-> $past(force_q) || $past(pend_q && ms_tick);
  endproperty
  a_resync: assert property (p_resync) else $error("spurious resync");

  property p_tick;
    @(posedge ref_clk) disable iff (!rst_n)
    second_q |=> !second_q [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick too close");
endmodule

// ---- test/trx_line_src.sv ----
// Line-side bit source: fixed pattern (mode 0) or PRBS in chosen slots, filler elsewhere
`timescale 1ns/1ps
module trx_line_src
  import trx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] pattern,
  input wire logic [4:0] len,
  input wire logic [NUM_SLOTS-1:0] slots,
  input wire logic flip,
  input wire logic [1:0] mode,
  output logic rx_bit,
  output logic rx_bit_en,
  output logic [4:0] rx_slot
);
  logic [8:0] pos_q;
  logic [4:0] idx_q;
  logic flip_q;
  logic hit;
  logic [19:0] lfsr_q;
  logic fb;

  // Taps follow x^15+x^14+1 (mode 1) and x^20+x^17+1 (mode 2)
  assign fb = mode == 2'h1 ? lfsr_q[14] ^ lfsr_q[13] :
    lfsr_q[19] ^ lfsr_q[16];

  // Slots 24..31 never carry pattern, so skipping is exercised
  assign hit = pos_q[8:4] < 5'h18 && slots[pos_q[8:4]];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_q <= 9'h000;
      idx_q <= 5'h00;
      flip_q <= 1'b0;
      lfsr_q <= 20'h00001;
      rx_bit <= 1'b0;
      rx_bit_en <= 1'b0;
      rx_slot <= 5'h00;
    end
    else
    begin
      pos_q <= pos_q + 9'h001;
      rx_bit_en <= pos_q[0];
      rx_slot <= pos_q[8:4];
      if (flip)
        flip_q <= 1'b1;
      if (pos_q[0] && hit && mode != 2'h0)
      begin
        rx_bit <= fb ^ flip_q;
        lfsr_q <= {lfsr_q[18:0], fb};
        flip_q <= flip;
      end
      else if (pos_q[0] && hit)
      begin
        // Top used bit first, wrapping after bit 0
        rx_bit <= pattern[idx_q] ^ flip_q;
        idx_q <= (idx_q == 5'h00) ? len : idx_q - 5'h01;
        flip_q <= flip;
      end
      else
        rx_bit <= ~rx_bit;
    end
  end
endmodule

// ---- test/trx_top_test.sv ----
// Register, vector, resync, counter and pattern tests of the block
`timescale 1ns/1ps
module trx_top_test
  import trx_pkg::*;
;
  localparam int MS = 4;
  localparam int SEC = 1000 * MS;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_bit;
  logic rx_bit_en;
  logic [4:0] rx_slot;
  logic [6:0] rx_alarm_lvl = 7'h00;
  logic rx_crc_evt = 1'b0;
  logic rx_tmr400_evt = 1'b0;
  logic rx_lof = 1'b0;
  logic [11:0] irq_vector;
  logic resync_start;
  logic pattern_sync;
  logic pattern_error;
  logic flip = 1'b0;
  logic [1:0] src_mode = 2'h0;
  logic [31:0] rd;
  logic [15:0] rst_tbl [7] = '{16'h001f, 16'h0000, 16'h0000, 16'hffff,
                               16'h00ff, 16'h0000, 16'h0000};
  logic [15:0] used_tbl [7] = '{16'h00ff, 16'hffff, 16'hffff, 16'hffff,
                                16'h00ff, 16'h0fff, 16'h001f};
  int errors = 0;
  int n_checks = 0;
  int rs_cnt = 0;
  int pe_cnt = 0;
  int rs0;
  int pe0;
  int t;

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    rs_cnt += (resync_start === 1'b1);
    pe_cnt += (pattern_error === 1'b1);
  end

  trx_top #(.MS_CYCLES(MS)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_bit(rx_bit),
    .rx_bit_en(rx_bit_en), .rx_slot(rx_slot), .rx_alarm_lvl(rx_alarm_lvl),
    .rx_crc_evt(rx_crc_evt), .rx_tmr400_evt(rx_tmr400_evt),
    .rx_lof(rx_lof), .irq_vector(irq_vector), .resync_start(resync_start),
    .pattern_sync(pattern_sync), .pattern_error(pattern_error));

  trx_line_src SRC (.ref_clk(ref_clk), .rst_n(rst_n),
    .pattern(32'hfffaa3c9), .len(5'h12), .slots(24'h020006), .flip(flip),
    .mode(src_mode),
    .rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .rx_slot(rx_slot));

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("unexpected at %0t ns: wait ran out", $time);
    end_of_test();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [15:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
      hang();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    check(rd, {16'h0000, exp});
  endtask

  // Kind 0 waits for sync, 1 for the second tick, 2 for a resync pulse
  task automatic wait_ev(input int k, input int lim);
    t = 0;
    do
    begin
      @(negedge ref_clk);
      t++;
    end
    while (!(k == 0 ? pattern_sync === 1'b1 : k == 1 ?
             irq_vector[VEC_SECOND] === 1'b1 : resync_start === 1'b1)
           && t < lim);
    if (t >= lim)
      hang();
    @(posedge ref_clk);
  endtask

  task automatic stim(input logic [6:0] lvl, input logic [1:0] ev,
                      input int vb, input logic exp);
    rx_alarm_lvl <= lvl;
    rx_crc_evt <= ev[0];
    rx_tmr400_evt <= ev[1];
    @(posedge ref_clk);
    rx_crc_evt <= 1'b0;
    rx_tmr400_evt <= 1'b0;
    @(negedge ref_clk);
    check(irq_vector[vb], exp);
    @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++)
    begin
      rd_chk(IDX_PMC + 6'(i), rst_tbl[i]);
      bus(1'b1, IDX_PMC + 6'(i), 16'hffff);
      rd_chk(IDX_PMC + 6'(i), used_tbl[i]);
      bus(1'b1, IDX_PMC + 6'(i), rst_tbl[i]);
    end
    bus(1'b1, 6'h3f, 16'hffff);
    rd_chk(6'h3f, 16'h0000);
    $display("test registers done");
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, IDX_MASK, m ? 16'h0fff : 16'h0000);
      for (int i = 0; i < 7; i++)
        stim(rx_alarm_lvl ^ (7'h01 << i), 2'b00, i ? i + 3 : 1, m == 0);
      stim(rx_alarm_lvl, 2'b01, VEC_CRC, m == 0);
      stim(rx_alarm_lvl, 2'b10, VEC_TMR400, m == 0);
    end
    bus(1'b1, IDX_MASK, 16'h0000);
    $display("test vectors done");
    rs0 = rs_cnt;
    bus(1'b1, IDX_CMD, 16'h0001);
    repeat (3) @(posedge ref_clk);
    check(rs_cnt - rs0, 1);
    bus(1'b1, IDX_MODE, 16'h0006);
    rx_lof <= 1'b1;
    wait_ev(2, 300);
    check(t >= 15 * MS && t <= 16 * MS + 3, 1);
    rx_lof <= 1'b0;
    bus(1'b1, IDX_MODE, 16'h0002);
    rs0 = rs_cnt;
    rx_lof <= 1'b1;
    bus(1'b1, IDX_CMD, 16'h0001);
    repeat (60) @(posedge ref_clk);
    check(rs_cnt - rs0, 1);
    rx_lof <= 1'b0;
    bus(1'b1, IDX_MODE, 16'h0000);
    $display("test resync done");
    bus(1'b0, IDX_CNT_CRC, 16'h0000);
    repeat (3) stim(rx_alarm_lvl, 2'b01, VEC_CRC, 1'b1);
    rd_chk(IDX_CNT_CRC, 16'h0003);
    rd_chk(IDX_CNT_CRC, 16'h0000);
    bus(1'b1, IDX_MODE, 16'h0001);
    wait_ev(1, SEC + 10);
    repeat (2) stim(rx_alarm_lvl, 2'b01, VEC_CRC, 1'b1);
    rd_chk(IDX_CNT_CRC, 16'h0000);
    wait_ev(1, SEC + 10);
    @(negedge ref_clk);
    check(irq_vector[VEC_ERRSEC], 1'b1);
    @(posedge ref_clk);
    rd_chk(IDX_CNT_CRC, 16'h0002);
    wait_ev(1, SEC + 10);
    wait_ev(1, SEC + 10);
    check(t, SEC);
    rd_chk(IDX_CNT_CRC, 16'h0000);
    bus(1'b1, IDX_MODE, 16'h0000);
    $display("test counters done");
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, IDX_PMC, 16'h0012 | 16'(c << PMC_SEL_LSB));
      rd_chk(IDX_PMC, 16'h0012 | 16'(c << PMC_SEL_LSB));
    end
    bus(1'b1, IDX_PAT_LO, 16'ha3c9);
    bus(1'b1, IDX_PAT_HI, 16'hfffa);
    bus(1'b1, IDX_SLOT_LO, 16'h0006);
    bus(1'b1, IDX_SLOT_HI, 16'h0002);
    bus(1'b1, IDX_PMC, 16'h00f2);
    wait_ev(0, 20000);
    @(negedge ref_clk);
    check(irq_vector[VEC_PATTERN], 1'b1);
    @(posedge ref_clk);
    check(pattern_sync, 1);
    rd_chk(IDX_CMD, 16'h0002);
    bus(1'b0, IDX_CNT_PAT, 16'h0000);
    pe0 = pe_cnt;
    repeat (1100) @(posedge ref_clk);
    check(pe_cnt - pe0, 0);
    flip <= 1'b1;
    @(posedge ref_clk);
    flip <= 1'b0;
    repeat (600) @(posedge ref_clk);
    check(pe_cnt - pe0, 1);
    check(pattern_sync, 1);
    rd_chk(IDX_CNT_PAT, 16'h0001);
    bus(1'b1, IDX_PMC, 16'h00d2);
    repeat (4) @(posedge ref_clk);
    check(pattern_sync, 0);
    bus(1'b1, IDX_PMC, 16'h00f2);
    wait_ev(0, 20000);
    bus(1'b1, IDX_PMC, 16'h0072);
    repeat (4) @(posedge ref_clk);
    check(pattern_sync, 0);
    for (int p = 1; p < 3; p++)
    begin
      src_mode <= 2'(p);
      bus(1'b1, IDX_PMC, 16'h0092 | 16'((p - 1) << PMC_SEL_LSB));
      wait_ev(0, 20000);
      pe0 = pe_cnt;
      repeat (600) @(posedge ref_clk);
      check(pe_cnt - pe0, 0);
      check(pattern_sync, 1);
      bus(1'b1, IDX_PMC, 16'h0012);
    end
    $display("test pattern done");
    end_of_test();
  end
endmodule
